// >>> src/uart_fifo_interrupt_select.sv
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
module uart_fifo_interrupt_select
  import irq_sel_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic [3:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  input wire occ_s OCC,
  output logic TX_IRQ_FLAG,
  output logic RX_IRQ_FLAG,
  output logic IRQ
);
  logic [15:0] ctrl_r;
  logic [1:0] stat_r;
  logic [1:0] stat_nxt;
  logic [1:0] mask_r;
  logic [15:0] rdata_r;
  logic [1:0] tx_irq_select;
  logic [1:0] rx_irq_select;
  logic tx_lvl, rx_lvl, tx_ev, rx_ev;
  logic tx_done, tx_empty, done_rise, empty_rise;

  // status read decode, shared by the clear path and its checks
  function automatic logic is_stat_rd(input logic rd, input logic [3:0] a);
    return rd && (a == ADDR_STAT);
  endfunction

  assign tx_irq_select = ctrl_r[TXSEL_LSB+:2];
  assign rx_irq_select = ctrl_r[RXSEL_LSB+:2];
  assign tx_done = OCC.tx_idle & (OCC.tx_free == CNT_FULL);
  assign tx_empty = OCC.tx_free == CNT_FULL;

  // level conditions: only exact counts qualify, a known defect kept as is
  always_comb begin
    tx_lvl = 1'b0;
    case (tx_irq_select)
      SEL_00: tx_lvl = OCC.tx_free == CNT_ONE;
      default: tx_lvl = 1'b0;
    endcase
    rx_lvl = 1'b0;
    case (rx_irq_select)
      SEL_00: rx_lvl = OCC.rx_count == CNT_ONE;
      SEL_01: rx_lvl = OCC.rx_count == CNT_HALF;
      SEL_10: rx_lvl = OCC.rx_count == CNT_3Q;
      default: rx_lvl = OCC.rx_count == CNT_FULL;
    endcase
  end

  irq_edge u_done (.clk(SYS_CLK), .rst_n(RST_N), .en(CE),
    .lvl(tx_done), .rise(done_rise));
  irq_edge u_empty (.clk(SYS_CLK), .rst_n(RST_N), .en(CE),
    .lvl(tx_empty), .rise(empty_rise));

  // events: completion is edge only, so a lasting idle line never re-arms
  always_comb begin
    case (tx_irq_select)
      SEL_01: tx_ev = done_rise;
      SEL_10: tx_ev = empty_rise;
      default: tx_ev = tx_lvl;
    endcase
    rx_ev = rx_lvl;
  end

  // sticky flags; read of status clears, a fresh event wins
  // level modes re-set while condition holds, edge modes do not
  always_comb begin
    stat_nxt = stat_r;
    if (is_stat_rd(RD, ADDR)) begin
      stat_nxt = 2'h0;
    end
    if (tx_ev) begin
      stat_nxt[0] = 1'b1;
    end
    if (rx_ev) begin
      stat_nxt[1] = 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      stat_r <= 2'h0;
    end else if (CE) begin
      stat_r <= stat_nxt;
    end
  end

  // control and mask writes
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      ctrl_r <= CTRL_RST;
      mask_r <= MASK_RST;
    end else if (CE && WR) begin
      if (ADDR == ADDR_CTRL) begin
        ctrl_r <= WDATA;
      end
      if (ADDR == ADDR_MASK) begin
        mask_r <= WDATA[1:0];
      end
    end
  end

  // read data valid the cycle after the strobe only
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      rdata_r <= 16'h0000;
    end else if (CE) begin
      rdata_r <= 16'h0000;
      if (RD) begin
        case (ADDR)
          ADDR_CTRL: rdata_r <= ctrl_r;
          ADDR_STAT: rdata_r <= {14'h0000, stat_r};
          ADDR_MASK: rdata_r <= {14'h0000, mask_r};
          ADDR_LVL: rdata_r <= {14'h0000, rx_lvl, tx_lvl};
          default: rdata_r <= 16'h0000;
        endcase
      end
    end
  end

  assign RDATA = rdata_r;
  assign TX_IRQ_FLAG = stat_r[0];
  assign RX_IRQ_FLAG = stat_r[1];
  assign IRQ = |(stat_r & mask_r);

  property p_tx_one;
    @(posedge SYS_CLK) disable iff (!RST_N)
      CE && tx_irq_select == SEL_00 && OCC.tx_free == CNT_ONE
      |=> TX_IRQ_FLAG;
  endproperty
  a_tx_one: assert property (p_tx_one) else $error("tx one free lost");

  property p_tx_many;
    @(posedge SYS_CLK) disable iff (!RST_N)
      CE && tx_irq_select == SEL_00 && OCC.tx_free > CNT_ONE
      |-> !tx_ev;
  endproperty
  a_tx_many: assert property (p_tx_many) else $error("tx many free");

  property p_rx_one;
    @(posedge SYS_CLK) disable iff (!RST_N)
      CE && rx_irq_select == SEL_00 && OCC.rx_count == CNT_ONE
      |=> RX_IRQ_FLAG;
  endproperty
  a_rx_one: assert property (p_rx_one) else $error("rx one lost");

  property p_rx_many;
    @(posedge SYS_CLK) disable iff (!RST_N)
      rx_irq_select == SEL_00 && OCC.rx_count > CNT_ONE |-> !rx_ev;
  endproperty
  a_rx_many: assert property (p_rx_many) else $error("rx many held");

  property p_done_once;
    @(posedge SYS_CLK) disable iff (!RST_N)
      CE && tx_irq_select == SEL_01 && tx_done && $past(tx_done)
      && $past(CE) |-> !tx_ev;
  endproperty
  a_done_once: assert property (p_done_once) else $error("done rearm");

  property p_done_set;
    @(posedge SYS_CLK) disable iff (!RST_N)
      CE && tx_irq_select == SEL_01 && done_rise |=> TX_IRQ_FLAG;
  endproperty
  a_done_set: assert property (p_done_set) else $error("done lost");

  property p_empty_once;
    @(posedge SYS_CLK) disable iff (!RST_N)
      CE && tx_irq_select == SEL_10 && tx_empty && $past(tx_empty)
      && $past(CE) |-> !tx_ev;
  endproperty
  a_empty_once: assert property (p_empty_once) else $error("empty");

  property p_rx_half;
    @(posedge SYS_CLK) disable iff (!RST_N)
      rx_irq_select == SEL_01 && OCC.rx_count != CNT_HALF |-> !rx_ev;
  endproperty
  a_rx_half: assert property (p_rx_half) else $error("rx half");

  property p_rx_3q;
    @(posedge SYS_CLK) disable iff (!RST_N)
      rx_irq_select == SEL_10 && OCC.rx_count != CNT_3Q |-> !rx_ev;
  endproperty
  a_rx_3q: assert property (p_rx_3q) else $error("rx 3q");

  property p_sticky;
    @(posedge SYS_CLK) disable iff (!RST_N)
      CE && TX_IRQ_FLAG && !(RD && ADDR == ADDR_STAT) |=> TX_IRQ_FLAG;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped");

  property p_empty_set;
    @(posedge SYS_CLK) disable iff (!RST_N)
      CE && tx_irq_select == SEL_10 && empty_rise |=> TX_IRQ_FLAG;
  endproperty
  a_empty_set: assert property (p_empty_set) else $error("empty lost");

  // exact-count rx thresholds must still raise the flag when met
  property p_half_set;
    @(posedge SYS_CLK) disable iff (!RST_N)
      CE && rx_irq_select == SEL_01 && OCC.rx_count == CNT_HALF
      |=> RX_IRQ_FLAG;
  endproperty
  a_half_set: assert property (p_half_set) else $error("half lost");

  property p_3q_set;
    @(posedge SYS_CLK) disable iff (!RST_N)
      CE && rx_irq_select == SEL_10 && OCC.rx_count == CNT_3Q
      |=> RX_IRQ_FLAG;
  endproperty
  a_3q_set: assert property (p_3q_set) else $error("3q lost");

  property p_rx_sticky;
    @(posedge SYS_CLK) disable iff (!RST_N)
      CE && RX_IRQ_FLAG && !is_stat_rd(RD, ADDR) |=> RX_IRQ_FLAG;
  endproperty
  a_rx_sticky: assert property (p_rx_sticky) else $error("rx dropped");

  // a read with no fresh event must leave the flag clear
  property p_clear;
    @(posedge SYS_CLK) disable iff (!RST_N)
      CE && is_stat_rd(RD, ADDR) && !tx_ev |=> !TX_IRQ_FLAG;
  endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared");

  // frozen clock enable: nothing moves, pending strobes are dropped
  property p_freeze;
    @(posedge SYS_CLK) disable iff (!RST_N)
      RST_N && !CE
      |=> $stable(stat_r) && $stable(ctrl_r) && $stable(mask_r);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved");
endmodule

// >>> src/irq_sel_pkg.sv
// Functional notes
// - tx sel 00: request while one free
// - tx sel 00: none if several free
// - rx sel 00: request while one held
// - rx sel 00: none if several held
// - tx sel 01: pulse on all shifted
// - cleared complete flag needs new event
// - tx sel 10: pulse on becoming empty
// - rx sel 01: only at exactly half
// - rx sel 10: only at exactly three quarters
package irq_sel_pkg;
  localparam int FIFO_DEPTH = 8;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  localparam logic [CNT_W-1:0] CNT_HALF = 4'h4;
  localparam logic [CNT_W-1:0] CNT_3Q = 4'h6;
  localparam logic [CNT_W-1:0] CNT_FULL = 4'h8;
  localparam logic [1:0] SEL_00 = 2'h0;
  localparam logic [1:0] SEL_01 = 2'h1;
  localparam logic [1:0] SEL_10 = 2'h2;
  // register indices on the plain port
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STAT = 4'h1;
  localparam logic [3:0] ADDR_MASK = 4'h2;
  localparam logic [3:0] ADDR_LVL = 4'h3;
  // control field positions
  localparam int TXSEL_LSB = 14;
  localparam int RXSEL_LSB = 6;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [1:0] MASK_RST = 2'h0;
  typedef struct packed {
    logic [CNT_W-1:0] tx_free;
    logic [CNT_W-1:0] rx_count;
    logic tx_idle;
  } occ_s;
endpackage

// >>> src/irq_edge.sv
`timescale 1ns/100ps
// rising-edge detector on a same-clock level
module irq_edge (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic lvl,
  output logic rise
);
  logic prev_r;
  // prev starts high so a level already true at reset is no event
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prev_r <= 1'b1;
    end else if (en) begin
      prev_r <= lvl;
    end
  end
  assign rise = en & lvl & ~prev_r;
endmodule

// >>> bench/occ_model.sv
`timescale 1ns/100ps
// far side: buffer counters and shifter as the serial side leaves them
module occ_model
  import irq_sel_pkg::*;
(
  input wire logic clk,
  input wire occ_s want,
  output occ_s occ
);
  // registered so occupancy moves on the clock like real counters
  always_ff @(posedge clk) begin
    occ <= want;
  end
endmodule

// >>> bench/tb_uart_fifo_interrupt_select.sv
`timescale 1ns/100ps
module tb_uart_fifo_interrupt_select
  import irq_sel_pkg::*;
;
  logic clk, rst_n, ce, wr_s, rd_s, tx_f, rx_f, irq;
  logic [3:0] addr;
  logic [15:0] wdata, rdata;
  occ_s want, occ;
  int bad_count, samples_checked;
  logic [15:0] rsel [2] = '{16'h0040, 16'h0080};
  logic [3:0] req [2] = '{CNT_HALF, CNT_3Q};
  occ_model partner (.clk(clk), .want(want), .occ(occ));
  uart_fifo_interrupt_select DUT (.SYS_CLK(clk), .RST_N(rst_n), .CE(ce),
    .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata),
    .OCC(occ), .TX_IRQ_FLAG(tx_f), .RX_IRQ_FLAG(rx_f), .IRQ(irq));
  // free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic cmp(input string what, input logic [15:0] e,
    input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    wr_s <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 cmp($sformatf("rdata %h", a), e, rdata);
  endtask
  // extra cycles let the model flop and the event flop land
  task automatic put(input logic [3:0] f, input logic [3:0] c,
    input logic i);
    @(posedge clk);
    want <= '{f, c, i};
    repeat (3) @(posedge clk);
  endtask
  task automatic test_done;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // hang guard
  initial begin
    #200000;
    bad_count++;
    test_done();
  end
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    wr_s = 1'b0;
    rd_s = 1'b0;
    addr = 4'h0;
    wdata = 16'h0000;
    want = '{4'h8, 4'h0, 1'b1};
    bad_count = 0;
    samples_checked = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    reg_rd(ADDR_CTRL, CTRL_RST);
    reg_rd(ADDR_MASK, {14'h0000, MASK_RST});
    reg_wr(4'h5, 16'hffff);
    reg_rd(4'h5, 16'h0000);
    put(4'h2, 4'h2, 1'b1);
    reg_rd(ADDR_STAT, 16'h0000);
    $display("test reset done");
    put(4'h1, 4'h1, 1'b1);
    #1 cmp("irq", 16'h0000, {15'h0000, irq});
    reg_wr(ADDR_MASK, 16'h0003);
    @(posedge clk);
    #1 cmp("irq", 16'h0001, {15'h0000, irq});
    reg_rd(ADDR_STAT, 16'h0003);
    reg_rd(ADDR_LVL, 16'h0003);
    put(4'h2, 4'h2, 1'b1);
    #1 cmp("flags", 16'h0003, {14'h0000, rx_f, tx_f});
    reg_rd(ADDR_STAT, 16'h0003);
    reg_rd(ADDR_STAT, 16'h0000);
    $display("test level done");
    // rx threshold modes: above, at, above again
    for (int k = 0; k < 2; k++) begin
      reg_wr(ADDR_CTRL, rsel[k]);
      put(4'h2, req[k] + 4'h1, 1'b1);
      reg_rd(ADDR_STAT, 16'h0000);
      put(4'h2, req[k], 1'b1);
      reg_rd(ADDR_STAT, 16'h0002);
      put(4'h2, req[k] + 4'h1, 1'b1);
      reg_rd(ADDR_STAT, 16'h0002);
      reg_rd(ADDR_STAT, 16'h0000);
    end
    $display("test rx done");
    reg_wr(ADDR_CTRL, 16'h4000);
    put(CNT_FULL, 4'h0, 1'b1);
    reg_rd(ADDR_STAT, 16'h0001);
    reg_rd(ADDR_STAT, 16'h0000);
    put(4'h7, 4'h0, 1'b0);
    put(CNT_FULL, 4'h0, 1'b1);
    reg_rd(ADDR_STAT, 16'h0001);
    put(4'h7, 4'h0, 1'b0);
    reg_wr(ADDR_CTRL, 16'h8000);
    reg_rd(ADDR_STAT, 16'h0000);
    put(CNT_FULL, 4'h0, 1'b0);
    reg_rd(ADDR_STAT, 16'h0001);
    reg_rd(ADDR_STAT, 16'h0000);
    $display("test tx done");
    // rx full mode: only an exactly full buffer counts
    reg_wr(ADDR_CTRL, 16'h00c0);
    put(CNT_FULL, 4'h7, 1'b0);
    reg_rd(ADDR_STAT, 16'h0000);
    put(CNT_FULL, CNT_FULL, 1'b0);
    reg_rd(ADDR_STAT, 16'h0002);
    put(CNT_FULL, 4'h7, 1'b0);
    reg_rd(ADDR_STAT, 16'h0002);
    reg_rd(ADDR_STAT, 16'h0000);
    $display("test rx full done");
    // ce low: strobes are dropped and events wait until it returns
    @(posedge clk);
    ce <= 1'b0;
    put(CNT_FULL, CNT_FULL, 1'b0);
    reg_wr(ADDR_MASK, 16'h0000);
    #1 cmp("flags", 16'h0000, {14'h0000, rx_f, tx_f});
    @(posedge clk);
    ce <= 1'b1;
    reg_rd(ADDR_MASK, 16'h0003);
    reg_rd(ADDR_STAT, 16'h0002);
    $display("test freeze done");
    // second reset in mid-run with the rx flag, both mask bits and rx full mode set
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    reg_rd(ADDR_CTRL, CTRL_RST);
    reg_rd(ADDR_MASK, {14'h0000, MASK_RST});
    reg_rd(ADDR_STAT, 16'h0000);
    $display("test reset again done");
    test_done();
  end
endmodule
